// ---- fdsp_target.sv ----
// Serial target port of the fan driver: register file, duty source and tach sharing.
// Assumes motor logic on the same clock supplies faults, temperature and events.
//
// Overview of operation
// - Serial mode speed from register 165
// - Demand code over 511 gives duty
// - Power-up uses speed pin as demand
// - Controller holds both pins low at power-up
// - Parameters at 64 plus word address
// - Writing 165 starts motor at demand
// - Undriven high speed pin means full duty
// - Register 128 shows applied duty
// - Register 138 shows die temperature code
// - Startup fail and try counters, zero writable
// - Register 148 latches seven lock flags
// - Bit 15 write clears lock flags
// - Clock on speed pin, data on tach
// - Transfers accepted without entry sequence
// - First command forces pin demand off
// - Tach may hold data low initially
// - Target address is 0x55
// - Write: address, register, two bytes MSB first
// - Read: set register, restart, two bytes back; controller sends stop then start
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module fdsp_target
  import fdsp_pkg::*;
(
  input  wire logic                          CLOCK_I,
  input  wire logic                          RST_B_I,
  fdsp_if.dev                                LINK,
  input  wire logic                          TACH_I,
  input  wire logic [fdsp_pkg::FAULT_W-1:0]  FAULT_I,
  input  wire logic [fdsp_pkg::LOCK_W-1:0]   LOCK_EVT_I,
  input  wire logic [fdsp_pkg::TEMP_W-1:0]   DIE_TEMP_I,
  input  wire logic                          START_FAIL_I,
  input  wire logic                          START_TRY_I,
  output logic      [fdsp_pkg::DUTY_W-1:0]   DUTY_O,
  output logic                               SERIAL_MODE_O,
  output logic                               STRAP_SERIAL_O
);
  import fdsp_pkg::*;

  typedef struct packed {
    fdsp_dst_t                   st;
    logic [3:0]                  cnt;
    logic [7:0]                  sh;
    logic [15:0]                 tx;
    logic                        rw;
    logic [1:0]                  nbyte;
    logic                        mack;
    logic [7:0]                  regad;
    logic [7:0]                  hi;
    logic                        sda_o;
    logic                        sda_oe_b;
    logic                        serial;
    logic                        strap;
    logic                        strap_done;
    logic [1:0]                  settle;
    logic [DUTY_W-1:0]           demand;
    logic [DUTY_W-1:0]           duty;
    logic [15:0]                 fails;
    logic [15:0]                 tries;
    logic [LOCK_W-1:0]           lock;
    logic [PARAM_N-1:0][15:0]    params;
  } fdsp_dev_state_t;

  fdsp_dev_state_t r_reg;
  fdsp_dev_state_t r_next;

  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  logic       scl_lvl;
  logic       sda_lvl;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda_rise;
  logic       sda_fall;
  logic [15:0] rdata;
  logic [15:0] wdata;
  logic        wr;
  logic [7:0]  pidx;
  logic        in_param;

  // Speed pin is the bus clock, tach pin the data line
  fdsp_sync #(.W(2), .INIT(2'h3)) u_sync (
    .clk_i   (CLOCK_I),
    .rst_b_i (RST_B_I),
    .d_i     ({LINK.scl, LINK.sda}),
    .lvl_o   (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  assign scl_lvl  = pin_lvl[1];
  assign sda_lvl  = pin_lvl[0];
  assign scl_rise = pin_rise[1];
  assign scl_fall = pin_fall[1];
  assign sda_rise = pin_rise[0];
  assign sda_fall = pin_fall[0];
  assign pidx     = r_reg.regad - PARAM_FIRST;
  assign in_param = (r_reg.regad >= PARAM_FIRST) && (r_reg.regad <= PARAM_LAST);

  // Read mux, unused bits zero
  always_comb begin
    rdata = 16'h0000;
    if (r_reg.regad == REG_APPLIED) begin
      rdata[DUTY_W-1:0] = r_reg.duty;
    end else if (r_reg.regad == REG_TEMP) begin
      rdata[TEMP_W-1:0] = DIE_TEMP_I;
    end else if (r_reg.regad == REG_FAILS) begin
      rdata = r_reg.fails;
    end else if (r_reg.regad == REG_TRIES) begin
      rdata = r_reg.tries;
    end else if (r_reg.regad == REG_FAULT) begin
      rdata[FAULT_W-1:0] = FAULT_I;
    end else if (r_reg.regad == REG_LOCK) begin
      rdata[LOCK_W-1:0] = r_reg.lock;
    end else if (r_reg.regad == REG_DEMAND) begin
      rdata[DUTY_W-1:0] = r_reg.demand;
    end else if (in_param) begin
      rdata = r_reg.params[pidx[4:0]];
    end
  end

  // Bus engine and register updates
  always_comb begin
    r_next = r_reg;
    wr     = 1'b0;
    wdata  = {r_reg.hi, r_reg.sh};
    // Strap taken once the synchroniser shows real pins, not its reset value
    if (!r_reg.strap_done) begin
      r_next.settle     = {r_reg.settle[0], 1'b1};
      r_next.strap_done = r_reg.settle[1];
      r_next.strap      = !scl_lvl && !sda_lvl;
    end
    if (scl_lvl && sda_fall) begin
      r_next.st       = D_ADDR;
      r_next.cnt      = 4'h0;
      r_next.sda_oe_b = 1'b1;
    end else if (scl_lvl && sda_rise) begin
      r_next.st       = D_IDLE;
      r_next.sda_oe_b = 1'b1;
    end else if (scl_rise) begin
      r_next.cnt = r_reg.cnt + 4'h1;
      r_next.sh  = {r_reg.sh[6:0], sda_lvl};
      if (r_reg.st == D_RDAT) begin
        r_next.tx = {r_reg.tx[14:0], 1'b0};
      end
      if (r_reg.st == D_RACK) begin
        r_next.mack = !sda_lvl;
      end
    end else if (scl_fall) begin
      case (r_reg.st)
        D_ADDR: begin
          if (r_reg.cnt == BYTE_BITS) begin
            if (r_reg.sh[7:1] == TGT_ADDR) begin
              r_next.st       = D_ACKA;
              r_next.rw       = r_reg.sh[0];
              r_next.sda_oe_b = 1'b0;
              r_next.serial   = 1'b1;
            end else begin
              r_next.st = D_IDLE;
            end
          end
        end
        D_ACKA: begin
          r_next.sda_oe_b = 1'b1;
          r_next.cnt      = 4'h0;
          r_next.nbyte    = 2'h0;
          if (r_reg.rw == RW_READ) begin
            r_next.st       = D_RDAT;
            r_next.tx       = rdata;
            r_next.sda_oe_b = rdata[15];
          end else begin
            r_next.st = D_REG;
          end
        end
        D_REG: begin
          if (r_reg.cnt == BYTE_BITS) begin
            r_next.regad    = r_reg.sh;
            r_next.sda_oe_b = 1'b0;
            r_next.st       = D_ACKR;
          end
        end
        D_ACKR, D_ACKW: begin
          r_next.sda_oe_b = 1'b1;
          r_next.cnt      = 4'h0;
          r_next.st       = D_WDAT;
          if (r_reg.st == D_ACKW && r_reg.nbyte != 2'h2) begin
            r_next.nbyte = r_reg.nbyte + 2'h1;
          end
        end
        D_WDAT: begin
          if (r_reg.cnt == BYTE_BITS) begin
            r_next.st = D_ACKW;
            // Extra bytes beyond two are not acknowledged
            r_next.sda_oe_b = (r_reg.nbyte == 2'h2);
            if (r_reg.nbyte == 2'h0) begin
              r_next.hi = r_reg.sh;
            end else if (r_reg.nbyte == 2'h1) begin
              wr = 1'b1;
            end
          end
        end
        D_RDAT: begin
          if (r_reg.cnt == BYTE_BITS) begin
            r_next.sda_oe_b = 1'b1;
            r_next.st       = D_RACK;
            r_next.cnt      = 4'h0;
          end else begin
            r_next.sda_oe_b = r_reg.tx[15];
          end
        end
        D_RACK: begin
          if (r_reg.mack && r_reg.nbyte == 2'h0) begin
            r_next.nbyte    = 2'h1;
            r_next.st       = D_RDAT;
            r_next.cnt      = 4'h0;
            r_next.sda_oe_b = r_reg.tx[15];
          end else begin
            r_next.st = D_IDLE;
          end
        end
        default: r_next.st = D_IDLE;
      endcase
    end
    // Tach shares the data pin until serial control takes over
    if (r_next.st == D_IDLE && !r_next.serial) begin
      r_next.sda_oe_b = TACH_I;
    end
    // Register writes; events added after a write so none is lost
    r_next.fails = ((wr && r_reg.regad == REG_FAILS) ? wdata : r_reg.fails)
                   + 16'(START_FAIL_I);
    r_next.tries = ((wr && r_reg.regad == REG_TRIES) ? wdata : r_reg.tries)
                   + 16'(START_TRY_I);
    r_next.lock  = ((wr && r_reg.regad == REG_LOCK && wdata[LOCK_CLR_BIT])
                   ? '0 : r_reg.lock) | LOCK_EVT_I;
    if (wr && r_reg.regad == REG_DEMAND) begin
      r_next.demand = wdata[DUTY_W-1:0];
    end
    for (int i = 0; i < PARAM_N; i++) begin
      if (wr && in_param && pidx == 8'(i)) begin
        r_next.params[i] = wdata;
      end
    end
    // Duty source: code n means n/511 of full duty
    if (r_next.serial) begin
      r_next.duty = r_next.demand;
    end else if (r_next.strap || !r_next.strap_done) begin // No full-duty blip before strap
      r_next.duty = DUTY_ZERO;
    end else begin
      r_next.duty = scl_lvl ? DUTY_FULL : DUTY_ZERO;
    end
  end

  // Single state register; outputs idle released
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      r_reg          <= '0;
      r_reg.st       <= D_IDLE;
      r_reg.sda_oe_b <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign LINK.sda_d_o    = r_reg.sda_o;
  assign LINK.sda_d_oe_b = r_reg.sda_oe_b;
  assign DUTY_O          = r_reg.duty;
  assign SERIAL_MODE_O   = r_reg.serial;
  assign STRAP_SERIAL_O  = r_reg.strap;
endmodule : fdsp_target

// ---- fdsp_pkg.sv ----
// Constants, types and register map shared by both ends of the fan driver serial port.
// Assumes a single core clock of 250 MHz on both ends.
package fdsp_pkg;

  // Link framing
  localparam logic [6:0] TGT_ADDR   = 7'h55;
  localparam logic       RW_WRITE   = 1'b0;
  localparam logic       RW_READ    = 1'b1;
  localparam logic [3:0] BYTE_BITS  = 4'h8;

  // Device register map
  localparam logic [7:0] REG_APPLIED  = 8'h80;
  localparam logic [7:0] REG_TEMP     = 8'h8a;
  localparam logic [7:0] REG_FAILS    = 8'h90;
  localparam logic [7:0] REG_TRIES    = 8'h91;
  localparam logic [7:0] REG_FAULT    = 8'h93;
  localparam logic [7:0] REG_LOCK     = 8'h94;
  localparam logic [7:0] REG_DEMAND   = 8'ha5;
  localparam logic [7:0] PARAM_BASE   = 8'h40;
  localparam logic [7:0] PARAM_FIRST  = PARAM_BASE + 8'h08;
  localparam logic [7:0] PARAM_LAST   = PARAM_BASE + 8'h1e;
  localparam int         PARAM_N      = 23;
  localparam int         LOCK_CLR_BIT = 15;

  // Field widths and duty codes
  localparam int         DUTY_W     = 9;
  localparam int         FAULT_W    = 10;
  localparam int         LOCK_W     = 7;
  localparam int         TEMP_W     = 8;
  localparam logic [8:0] DUTY_FULL  = 9'h1ff;
  localparam logic [8:0] DUTY_ZERO  = 9'h000;

  // Controller APB map
  localparam logic [7:0] HREG_CTRL  = 8'h00;
  localparam logic [7:0] HREG_WDATA = 8'h04;
  localparam logic [7:0] HREG_RDATA = 8'h08;
  localparam logic [7:0] HREG_STAT  = 8'h0c;
  localparam int         CTRL_RW    = 8;
  localparam int         CTRL_GO    = 9;

  // Fast mode bus timing: quarter of a 2500 ns bit, rounded up
  localparam int CLK_NS     = 4;
  localparam int T_QTR_NS   = 625;
  localparam int QTR_CYC    = (T_QTR_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [8:0] {
    D_IDLE = 9'h001, D_ADDR = 9'h002, D_ACKA = 9'h004,
    D_REG  = 9'h008, D_ACKR = 9'h010, D_WDAT = 9'h020,
    D_ACKW = 9'h040, D_RDAT = 9'h080, D_RACK = 9'h100
  } fdsp_dst_t;

  typedef enum logic [1:0] {H_IDLE = 2'h1, H_RUN = 2'h2} fdsp_hst_t;

  typedef enum logic [5:0] {
    OP_START = 6'h01, OP_TX = 6'h02, OP_RXA = 6'h04,
    OP_RXN   = 6'h08, OP_STOP = 6'h10, OP_END = 6'h20
  } fdsp_op_t;

endpackage : fdsp_pkg

// ---- fdsp_if.sv ----
// Two-wire link between the controller and the fan driver port.
// Both data drivers are open drain; the clock is driven by the controller only.
`timescale 1ns/1ps
interface fdsp_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe_b;
  logic sda_d_o;
  logic sda_d_oe_b;
  logic sda;

  // Wired-and data line with pull-up
  assign sda = (sda_m_oe_b | sda_m_o) & (sda_d_oe_b | sda_d_o);

  modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe_b);
  modport host (output scl, output sda_m_o, output sda_m_oe_b, input sda);
endinterface : fdsp_if

// ---- fdsp_sync.sv ----
// Two-flop synchroniser with edge detection for asynchronous pins.
// Assumes inputs are slow against the core clock.
`timescale 1ns/1ps
module fdsp_sync #(
  parameter int             W    = 2,
  parameter logic [W-1:0]   INIT = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } fdsp_sync_state_t;

  fdsp_sync_state_t s_reg;
  fdsp_sync_state_t s_next;

  // Only the second stage looks at the first
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d_i;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= {INIT, INIT, INIT};
    end else begin
      s_reg <= s_next;
    end
  end

  // Edges from settled stages only
  assign lvl_o  = s_reg.s2;
  assign rise_o = s_reg.s2 & ~s_reg.s3;
  assign fall_o = ~s_reg.s2 & s_reg.s3;
endmodule : fdsp_sync

// ---- fdsp_master.sv ----
// Bus controller for the fan driver port, commanded by software over APB.
// Assumes APB on the core clock; the bus clock is divided down from it.
`timescale 1ns/1ps
module fdsp_master
  import fdsp_pkg::*;
#(
  parameter int QTR = fdsp_pkg::QTR_CYC
) (
  input  wire logic         CLOCK_I,
  input  wire logic         RST_B_I,
  fdsp_if.host              LINK,
  input  wire logic         PSEL_I,
  input  wire logic         PENABLE_I,
  input  wire logic         PWRITE_I,
  input  wire logic [7:0]   PADDR_I,
  input  wire logic [31:0]  PWDATA_I,
  output logic      [31:0]  PRDATA_O,
  output logic              PREADY_O,
  output logic              PSLVERR_O
);
  import fdsp_pkg::*;

  typedef struct packed {
    fdsp_hst_t   st;
    logic [3:0]  step;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [15:0] qc;
    logic [7:0]  sh;
    logic [15:0] rxd;
    logic [7:0]  regad;
    logic        rw;
    logic [15:0] wdata;
    logic        busy;
    logic        nack;
    logic        done;
    logic        hold;
    logic        scl;
    logic        sda_oe_b;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fdsp_host_state_t;

  fdsp_host_state_t r_reg;
  fdsp_host_state_t r_next;
  logic             sda_lvl;
  fdsp_op_t         op;
  fdsp_op_t         nop;
  logic             tick;
  logic             acc;

  // Op sequence of a write and of a read
  function automatic fdsp_op_t op_of(input logic [3:0] s, input logic rd);
    fdsp_op_t o;
    o = OP_END;
    if (s == 4'h0 || (rd && s == 4'h4)) begin
      o = OP_START;
    end else if (s <= 4'h2 || (!rd && s <= 4'h4) || (rd && s == 4'h5)) begin
      o = OP_TX;
    end else if (rd && s == 4'h6) begin
      o = OP_RXA;
    end else if (rd && s == 4'h7) begin
      o = OP_RXN;
    end else if ((!rd && s == 4'h5) || (rd && (s == 4'h3 || s == 4'h8))) begin
      o = OP_STOP;
    end
    return o;
  endfunction : op_of

  // Byte sent at each transmit step, MSB first
  function automatic logic [7:0] byte_of(input logic [3:0] s, input logic rd,
                                         input logic [7:0] ra, input logic [15:0] wd);
    logic [7:0] b;
    b = {TGT_ADDR, RW_WRITE};
    if (s == 4'h2) begin
      b = ra;
    end else if (s == 4'h3) begin
      b = wd[15:8];
    end else if (s == 4'h4) begin
      b = wd[7:0];
    end else if (rd && s == 4'h5) begin
      b = {TGT_ADDR, RW_READ};
    end
    return b;
  endfunction : byte_of

  // Data line back through the synchroniser
  fdsp_sync #(.W(1), .INIT(1'h1)) u_sync (
    .clk_i   (CLOCK_I),
    .rst_b_i (RST_B_I),
    .d_i     (LINK.sda),
    .lvl_o   (sda_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  assign op   = op_of(r_reg.step, r_reg.rw);
  assign tick = (r_reg.qc == 16'(QTR - 1));
  assign acc  = PSEL_I && PENABLE_I && r_reg.pready;

  always_comb begin
    r_next         = r_reg;
    // APB: answer ready in the cycle after setup
    r_next.pready  = PSEL_I && !PENABLE_I;
    if (PSEL_I && !PENABLE_I) begin
      r_next.prdata  = 32'h0000_0000;
      r_next.pslverr = 1'b0;
      if (PADDR_I == HREG_CTRL) begin
        r_next.prdata[9:0] = {1'b0, r_reg.rw, r_reg.regad};
      end else if (PADDR_I == HREG_WDATA) begin
        r_next.prdata[15:0] = r_reg.wdata;
      end else if (PADDR_I == HREG_RDATA) begin
        r_next.prdata[15:0] = r_reg.rxd;
      end else if (PADDR_I == HREG_STAT) begin
        r_next.prdata[2:0] = {r_reg.done, r_reg.nack, r_reg.busy};
      end else begin
        r_next.pslverr = 1'b1;
      end
    end
    // Commands are ignored while a transfer runs
    if (acc && PWRITE_I && !r_reg.busy) begin
      if (PADDR_I == HREG_CTRL) begin
        r_next.regad = PWDATA_I[7:0];
        r_next.rw    = PWDATA_I[CTRL_RW];
        if (PWDATA_I[CTRL_GO]) begin
          r_next.st   = H_RUN;
          r_next.busy = 1'b1;
          r_next.done = 1'b0;
          r_next.nack = 1'b0;
          r_next.hold = 1'b0;
          r_next.step = 4'h0;
          r_next.ph   = 2'h0;
          r_next.bitn = 4'h0;
          r_next.qc   = 16'h0000;
        end
      end else if (PADDR_I == HREG_WDATA) begin
        r_next.wdata = PWDATA_I[15:0];
      end
    end
    // Bit engine, four quarter phases per bit
    if (r_reg.st == H_RUN) begin
      r_next.qc = r_reg.qc + 16'h0001;
      if (op == OP_END) begin
        r_next.st   = H_IDLE;
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end else if (tick) begin
        r_next.qc = 16'h0000;
        // Wait out a tach that still pulls data low
        if (!(op == OP_START && r_reg.ph == 2'h0 && !sda_lvl)) begin
          r_next.ph = r_reg.ph + 2'h1;
        end
        if (r_reg.ph == 2'h2 && (op == OP_RXA || op == OP_RXN)
            && r_reg.bitn < BYTE_BITS) begin
          r_next.rxd = {r_reg.rxd[14:0], sda_lvl};
        end
        if (r_reg.ph == 2'h2 && op == OP_TX && r_reg.bitn == BYTE_BITS
            && sda_lvl) begin
          r_next.nack = 1'b1;
          r_next.step = r_reg.rw ? 4'h8 : 4'h5;
          r_next.bitn = 4'h0;
          r_next.ph   = 2'h0;
        end else if (r_reg.ph == 2'h3) begin
          if (op == OP_START || op == OP_STOP || r_reg.bitn == BYTE_BITS) begin
            r_next.step = r_reg.step + 4'h1;
            r_next.bitn = 4'h0;
            r_next.sh   = byte_of(r_next.step, r_reg.rw, r_reg.regad, r_reg.wdata);
          end else begin
            r_next.bitn = r_reg.bitn + 4'h1;
            r_next.sh   = {r_reg.sh[6:0], 1'b0};
          end
        end
      end
    end
    // Op of the step being entered; computed here to keep the loop inside one process
    nop = op_of(r_next.step, r_next.rw);
    // Pin levels from the phase being entered
    if (r_next.st != H_RUN) begin
      r_next.scl      = !r_next.hold;
      r_next.sda_oe_b = !r_next.hold;
    end else if (nop == OP_START) begin
      r_next.scl      = (r_next.ph <= 2'h1);
      r_next.sda_oe_b = (r_next.ph == 2'h0);
    end else if (nop == OP_STOP) begin
      r_next.scl      = (r_next.ph != 2'h0);
      r_next.sda_oe_b = (r_next.ph >= 2'h2);
    end else if (nop == OP_END) begin
      r_next.scl      = 1'b1;
      r_next.sda_oe_b = 1'b1;
    end else begin
      r_next.scl = (r_next.ph == 2'h1) || (r_next.ph == 2'h2);
      if (r_next.bitn == BYTE_BITS) begin
        r_next.sda_oe_b = (nop != OP_RXA);
      end else begin
        r_next.sda_oe_b = (nop == OP_TX) ? r_next.sh[7] : 1'b1;
      end
    end
  end

  // Reset holds both lines low until the first command
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      r_reg      <= '0;
      r_reg.st   <= H_IDLE;
      r_reg.hold <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign LINK.scl        = r_reg.scl;
  assign LINK.sda_m_o    = 1'b0;
  assign LINK.sda_m_oe_b = r_reg.sda_oe_b;
  assign PRDATA_O        = r_reg.prdata;
  assign PREADY_O        = r_reg.pready;
  assign PSLVERR_O       = r_reg.pslverr;
endmodule : fdsp_master

// ---- fdsp_props.sv ----
// Link checker for the fan driver serial port: framing, ack and open drain.
// Assumes it sees the interface wires and the core clock shared by both ends.
`timescale 1ns/1ps
module fdsp_props
  import fdsp_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic scl,
  input wire logic sda_m_o,
  input wire logic sda_m_oe_b,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_b,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       rise;
  logic [3:0] nbit;
  logic [7:0] sh;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);

  // Bit counter restarted by a start; saturates so only the address byte is seen
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      scl_q <= 1'b0;
      sda_q <= 1'b1;
      nbit  <= 4'h0;
      sh    <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        nbit <= 4'h0;
      end else if (rise && nbit != 4'hf) begin
        nbit <= nbit + 4'h1;
        sh   <= {sh[6:0], sda};
      end
    end
  end

  // Bus clock rising edge seen by the core clock
  assign rise = scl && !scl_q;

  a_dev_open_drain: assert property (sda_d_oe_b || !sda_d_o)
    else $error("target drives data line high");
  a_ctl_open_drain: assert property (sda_m_oe_b || !sda_m_o)
    else $error("controller drives data line high");
  a_addr_ack: assert property (rise && nbit == 4'h8 && sh[7:1] == TGT_ADDR |-> !sda_d_oe_b [*8])
    else $error("own address not acknowledged");
  a_ack_release: assert property (rise && nbit == 4'h8 |-> sda_m_oe_b)
    else $error("controller holds data during ack bit");
  a_dev_stable_high: assert property (scl && scl_q |-> $stable(sda_d_oe_b))
    else $error("target changed data while clock high");
  a_stop_quiet: assert property (scl && scl_q && !sda_q && sda |-> sda_d_oe_b [*4])
    else $error("target pulls data after stop");
  a_start_bound: assert property (scl && scl_q && sda_q && !sda |-> ##[1:64] !scl)
    else $error("clock not lowered after start");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*4])
    else $error("bus clock low phase too short");

  // Main link events reached by the bench
  c_addr_ack: cover property (rise && nbit == 4'h8 && !sda);
  c_read_dir: cover property (rise && nbit == 4'h8 && sh[0]);
  c_stop: cover property (scl && scl_q && !sda_q && sda);
endmodule : fdsp_props

// ---- fan_driver_serial_control_port_tb.sv ----
// Bench joining the bus controller and the fan driver port over the link.
// Assumes the controller APB map of the package and a quarter bit of 8 cycles.
`timescale 1ns/1ps
module fan_driver_serial_control_port_tb;
  import fdsp_pkg::*;
  typedef struct {logic [7:0] ra; logic [15:0] wd; logic [15:0] ex;} fdsp_row_t;
  logic        CLOCK_I = 1'b0;
  logic        RST_B_I = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tach = 1'b0, fail = 1'b0, tries = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0]  fault = 10'h2a5;
  logic [6:0]  lock = 7'h00;
  logic [7:0]  temp = 8'h85;
  logic [31:0] prdata, r;
  logic        pready, pslverr, serial, e, strap;
  logic [8:0]  duty;
  logic [15:0] rv;
  int          bad_count = 0, check_count = 0;
  // Write each row, read it back, expect the last column
  fdsp_row_t   rows [9] = '{
    '{8'ha5, 16'h0066, 16'h0066},
    '{8'h48, 16'h1234, 16'h1234},
    '{8'h5e, 16'hbeef, 16'hbeef},
    '{8'h47, 16'h5555, 16'h0000},
    '{8'h80, 16'h0000, 16'h0066},
    '{8'h8a, 16'h0000, 16'h0085},
    '{8'h93, 16'hffff, 16'h02a5},
    '{8'hc0, 16'hffff, 16'h0000},
    '{8'ha5, 16'hffff, 16'h01ff}};

  always #2 CLOCK_I = ~CLOCK_I;

  fdsp_if lnk ();
  fdsp_master #(.QTR(8)) i_fdsp_master (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .LINK(lnk.host),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
  fdsp_target i_fdsp_target (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .LINK(lnk.dev),
    .TACH_I(tach), .FAULT_I(fault), .LOCK_EVT_I(lock), .DIE_TEMP_I(temp), .START_FAIL_I(fail),
    .START_TRY_I(tries), .DUTY_O(duty), .SERIAL_MODE_O(serial), .STRAP_SERIAL_O(strap));
  fdsp_props i_fdsp_props (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .scl(lnk.scl),
    .sda_m_o(lnk.sda_m_o), .sda_m_oe_b(lnk.sda_m_oe_b), .sda_d_o(lnk.sda_d_o),
    .sda_d_oe_b(lnk.sda_d_oe_b), .sda(lnk.sda));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLOCK_I);
    penable <= 1'b1;
    while (pready !== 1'b1) @(posedge CLOCK_I);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge CLOCK_I);
  endtask : apb

  // One link command through the controller; polls busy, the watchdog ends a hang
  task automatic xfer(input logic rd, input logic [7:0] ra, input logic [15:0] wd);
    apb(1'b1, HREG_WDATA, {16'h0000, wd});
    apb(1'b1, HREG_CTRL, {23'h00_0001, rd, ra});
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) apb(1'b0, HREG_STAT, 32'h0000_0000);
    chk({15'h0000, r[1]}, 16'h0000);
    apb(1'b0, HREG_RDATA, 32'h0000_0000);
    rv = r[15:0];
  endtask : xfer

  // Cuts a hang short; the tests need well under half this span
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge CLOCK_I);
    RST_B_I <= 1'b1;
    repeat (4) @(posedge CLOCK_I);
    chk({7'h00, duty}, 16'h0000);
    chk({15'h0000, serial}, 16'h0000);
    chk({15'h0000, strap}, 16'h0001);
    tach <= 1'b1;
    @(posedge CLOCK_I);
    $display("reset test done");
    xfer(1'b1, REG_APPLIED, 16'h0000);
    chk(rv, 16'h0000);
    foreach (rows[i]) begin
      xfer(1'b0, rows[i].ra, rows[i].wd);
      xfer(1'b1, rows[i].ra, 16'h0000);
      chk(rv, rows[i].ex);
    end
    chk({7'h00, duty}, 16'h01ff);
    chk({15'h0000, serial}, 16'h0001);
    $display("register rows done");
    // Event pulses: three tries, one failure, a lock pattern
    repeat (3) begin
      tries <= 1'b1;
      @(posedge CLOCK_I);
      tries <= 1'b0;
      @(posedge CLOCK_I);
    end
    fail <= 1'b1;
    lock <= 7'h45;
    @(posedge CLOCK_I);
    fail <= 1'b0;
    lock <= 7'h00;
    xfer(1'b1, REG_TRIES, 16'h0000);
    chk(rv, 16'h0003);
    xfer(1'b1, REG_FAILS, 16'h0000);
    chk(rv, 16'h0001);
    xfer(1'b0, REG_TRIES, 16'h0000);
    xfer(1'b1, REG_TRIES, 16'h0000);
    chk(rv, 16'h0000);
    $display("counter test done");
    xfer(1'b1, REG_LOCK, 16'h0000);
    chk(rv, 16'h0045);
    xfer(1'b0, REG_LOCK, 16'h8000);
    xfer(1'b1, REG_LOCK, 16'h0000);
    chk(rv, 16'h0000);
    $display("lock test done");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({15'h0000, e}, 16'h0001);
    chk(r[15:0], 16'h0000);
    $display("apb error test done");
    report_and_stop();
  end
endmodule : fan_driver_serial_control_port_tb
